// file: gofs_pkg.sv
// Constants for the pin output function selector: codes, register map, reset values.
package gofs_pkg;

   // Pin geometry.
   localparam int          PIN_COUNT     = 16;
   localparam int          LOW_PIN_COUNT = 8;
   localparam int          CODE_W        = 10;

   // Function codes.
   localparam logic [9:0]  FN_AUX_CLOCK  = 10'h048;
   localparam logic [9:0]  FN_PWM_ONE    = 10'h080;
   localparam logic [9:0]  FN_PWM_TWO    = 10'h081;
   localparam logic [9:0]  FN_PATH_DET   = 10'h08C;
   localparam logic [9:0]  FN_ULTRA_ONE  = 10'h090;
   localparam logic [9:0]  FN_ULTRA_TWO  = 10'h092;
   localparam logic [9:0]  FN_EVLOG_FULL = 10'h158;
   localparam logic [9:0]  FN_ALARM_BASE = 10'h230;
   localparam logic [9:0]  FN_ALARM_LAST = 10'h233;
   localparam logic [9:0]  FN_TIMER_ONE  = 10'h250;
   localparam logic [9:0]  FN_TIMER_TWO  = 10'h251;
   localparam logic [9:0]  FN_NONE       = 10'h000;

   // Register byte offsets on the APB slave.
   localparam logic [7:0]  OFS_FN_SEL0   = 8'h00;
   localparam logic [7:0]  OFS_AUX_DIV   = 8'h40;
   localparam logic [7:0]  OFS_PULSE_LEN = 8'h44;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h48;
   localparam logic [7:0]  OFS_IRQ_MASK  = 8'h4C;
   localparam logic [7:0]  OFS_PIN_LEVEL = 8'h50;

   // Field widths and reset values.
   localparam int          DIV_W         = 16;
   localparam int          LEN_W         = 8;
   localparam int          EVT_W         = 7;
   localparam logic [15:0] AUX_DIV_RST   = 16'h0001;
   localparam logic [7:0]  PULSE_LEN_RST = 8'h04;
   localparam logic [6:0]  IRQ_MASK_RST  = 7'h00;

   // Interrupt status bit positions.
   localparam int          EVT_ALARM_LSB = 0;
   localparam int          EVT_TIMER_LSB = 4;
   localparam int          EVT_BAD_SEL   = 6;

endpackage : gofs_pkg

// file: gofs_clk_div.sv
// Divider that makes the auxiliary clock level from the system clock.
`timescale 1ns/1ps
module gofs_clk_div #(
   parameter int DIV_W = 16
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             nrst,
   // Half period in system clock cycles; zero acts as one.
   input  wire logic [DIV_W-1:0] halfPeriod,
   // Divided clock level.
   output logic                  auxClk
);

   if (DIV_W < 1) begin : gBadWidth
      $error("gofs_clk_div: DIV_W must be at least 1");
   end

   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic             auxClk_q;
   wire  logic [DIV_W-1:0] limit = (halfPeriod == '0) ? DIV_W'(1) : halfPeriod;
   wire  logic             tick  = (cnt_q >= limit - DIV_W'(1));

   assign cnt_d  = tick ? '0 : cnt_q + DIV_W'(1);
   assign auxClk = auxClk_q;

   // One-cycle enable at each half period toggles the output level.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q    <= '0;
         auxClk_q <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         auxClk_q <= auxClk_q ^ tick;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_div_toggle_rate: assert property (tick |=> auxClk_q != $past(auxClk_q))
      else $error("aux clock did not toggle on divider tick");

endmodule : gofs_clk_div

// file: gofs_pulse_stretch.sv
// Stretches a one-cycle alarm trigger into a pulse of programmable length.
`timescale 1ns/1ps
module gofs_pulse_stretch #(
   parameter int LEN_W = 8
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             nrst,
   // Trigger and programmed length in cycles; zero acts as one.
   input  wire logic             trig,
   input  wire logic [LEN_W-1:0] pulseLen,
   // Stretched pulse.
   output logic                  pulseOut
);

   if (LEN_W < 1) begin : gBadWidth
      $error("gofs_pulse_stretch: LEN_W must be at least 1");
   end

   logic [LEN_W-1:0] left_q;
   wire  logic [LEN_W-1:0] effLen = (pulseLen == '0) ? LEN_W'(1) : pulseLen;

   assign pulseOut = (left_q != '0);

   // A new trigger restarts the pulse at full length.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         left_q <= '0;
      end else if (trig) begin
         left_q <= effLen;
      end else if (left_q != '0) begin
         left_q <= left_q - LEN_W'(1);
      end
   end

   // Helper: cycles since the latest trigger.
   logic [LEN_W:0] since_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         since_q <= '0;
      end else if (trig) begin
         since_q <= (LEN_W+1)'(1);
      end else if (since_q != '1) begin
         since_q <= since_q + (LEN_W+1)'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_pulse_length: assert property ($fell(pulseOut) |->
         $past(since_q) == {1'b0, $past(effLen)})
      else $error("alarm pulse length differs from programmed length");
   a_pulse_start: assert property (trig |=> pulseOut)
      else $error("alarm pulse did not start after trigger");

endmodule : gofs_pulse_stretch

// file: gofs_top.sv
// Output function selector for the sixteen general-purpose pins, with APB registers.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module gofs_top #(
   parameter int DIV_W = gofs_pkg::DIV_W,
   parameter int LEN_W = gofs_pkg::LEN_W
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        nrst,
   // APB slave.
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Internal sources.
   input  wire logic        pulseWidthOutOne,
   input  wire logic        pulseWidthOutTwo,
   input  wire logic        inputPathDetect,
   input  wire logic        ultrasonicDetectorOne,
   input  wire logic        ultrasonicDetectorTwo,
   input  wire logic        eventLogNotEmpty,
   input  wire logic [3:0]  alarmTrig,
   input  wire logic [1:0]  timerDone,
   // Pins.
   output logic [15:0]      pinOut,
   output logic [15:0]      pinOe,
   // Interrupt.
   output logic             irq
);

   // Register fields are cut from one 32-bit data word, so wider fields cannot be served.
   if (DIV_W < 1 || DIV_W > 32) begin : gBadDiv
      $error("gofs_top: DIV_W must be 1 to 32");
   end
   if (LEN_W < 1 || LEN_W > 32) begin : gBadLen
      $error("gofs_top: LEN_W must be 1 to 32");
   end

   localparam int NP = gofs_pkg::PIN_COUNT;
   localparam int EW = gofs_pkg::EVT_W;

   // Source bundle positions used by the routing function.
   localparam int S_AUX       = 0;
   localparam int S_PWM_ONE   = 1;
   localparam int S_PWM_TWO   = 2;
   localparam int S_PATH      = 3;
   localparam int S_ULTRA_ONE = 4;
   localparam int S_ULTRA_TWO = 5;
   localparam int S_EVLOG     = 6;
   localparam int S_ALARM     = 7;
   localparam int S_TIMER     = 11;
   localparam int SRC_W       = 13;

   // True when the code may be driven on a pin of the given range.
   function automatic logic gofsAllowed(input logic [9:0] code, input logic lowPin);
      logic anyPin;
      logic lowOnly;
      anyPin  = (code == gofs_pkg::FN_PWM_ONE) || (code == gofs_pkg::FN_PWM_TWO)
              || (code >= gofs_pkg::FN_ALARM_BASE && code <= gofs_pkg::FN_ALARM_LAST)
              || (code == gofs_pkg::FN_TIMER_ONE) || (code == gofs_pkg::FN_TIMER_TWO);
      lowOnly = (code == gofs_pkg::FN_AUX_CLOCK) || (code == gofs_pkg::FN_PATH_DET)
              || (code == gofs_pkg::FN_ULTRA_ONE) || (code == gofs_pkg::FN_ULTRA_TWO)
              || (code == gofs_pkg::FN_EVLOG_FULL);
      return anyPin || (lowOnly && lowPin);
   endfunction : gofsAllowed

   // Level of the source that a code selects.
   function automatic logic gofsLevel(input logic [9:0] code, input logic [SRC_W-1:0] src);
      logic [9:0] alarmIdx;
      alarmIdx = code - gofs_pkg::FN_ALARM_BASE;
      case (code)
         gofs_pkg::FN_AUX_CLOCK:  return src[S_AUX];
         gofs_pkg::FN_PWM_ONE:    return src[S_PWM_ONE];
         gofs_pkg::FN_PWM_TWO:    return src[S_PWM_TWO];
         gofs_pkg::FN_PATH_DET:   return src[S_PATH];
         gofs_pkg::FN_ULTRA_ONE:  return src[S_ULTRA_ONE];
         gofs_pkg::FN_ULTRA_TWO:  return src[S_ULTRA_TWO];
         gofs_pkg::FN_EVLOG_FULL: return src[S_EVLOG];
         gofs_pkg::FN_TIMER_ONE:  return src[S_TIMER];
         gofs_pkg::FN_TIMER_TWO:  return src[S_TIMER + 1];
         default: begin
            if (code >= gofs_pkg::FN_ALARM_BASE && code <= gofs_pkg::FN_ALARM_LAST) begin
               return src[S_ALARM + int'(alarmIdx[1:0])];
            end
            return 1'b0;
         end
      endcase
   endfunction : gofsLevel

   // Registers.
   logic [9:0]       fnSel_q [NP];
   logic [DIV_W-1:0] auxDiv_q;
   logic [LEN_W-1:0] pulseLen_q;
   logic [EW-1:0]    irqStat_q;
   logic [EW-1:0]    irqStat_d;
   logic [EW-1:0]    irqMask_q;
   logic [3:0]       alarmPulseDly_q;
   logic [15:0]      pinOut_q;
   logic [15:0]      pinOe_q;
   wire logic [15:0] pinOut_d;
   wire logic [15:0] pinOe_d;
   logic             irq_q;
   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;

   // Source generators.
   logic       auxClk;
   logic [3:0] alarmPulse;

   gofs_clk_div #(.DIV_W(DIV_W)) uClkDiv (
      .clk        (clk),
      .nrst       (nrst),
      .halfPeriod (auxDiv_q),
      .auxClk     (auxClk)
   );

   genvar a;
   generate
      for (a = 0; a < 4; a++) begin : gAlarm
         gofs_pulse_stretch #(.LEN_W(LEN_W)) uStretch (
            .clk      (clk),
            .nrst     (nrst),
            .trig     (alarmTrig[a]),
            .pulseLen (pulseLen_q),
            .pulseOut (alarmPulse[a])
         );
      end
   endgenerate

   wire logic [SRC_W-1:0] srcVec = {timerDone, alarmPulse, eventLogNotEmpty,
                                    ultrasonicDetectorTwo, ultrasonicDetectorOne,
                                    inputPathDetect, pulseWidthOutTwo, pulseWidthOutOne,
                                    auxClk};

   // APB decode.
   wire logic       apbAccess = psel & penable;
   wire logic       apbFirst  = apbAccess & ~pready_q;
   wire logic       apbDone   = apbAccess & pready_q;
   wire logic       aligned   = (paddr[1:0] == 2'h0);
   wire logic       hitFnSel  = aligned && (paddr < gofs_pkg::OFS_AUX_DIV);
   wire logic [3:0] selIdx    = paddr[5:2];
   wire logic       hitDiv    = aligned && (paddr == gofs_pkg::OFS_AUX_DIV);
   wire logic       hitLen    = aligned && (paddr == gofs_pkg::OFS_PULSE_LEN);
   wire logic       hitStat   = aligned && (paddr == gofs_pkg::OFS_IRQ_STAT);
   wire logic       hitMask   = aligned && (paddr == gofs_pkg::OFS_IRQ_MASK);
   wire logic       hitLevel  = aligned && (paddr == gofs_pkg::OFS_PIN_LEVEL);
   wire logic       mapped    = hitFnSel | hitDiv | hitLen | hitStat | hitMask | hitLevel;
   wire logic       wrEn      = apbDone & pwrite & mapped;
   wire logic       wrLevelErr = pwrite & hitLevel;

   wire logic [31:0] readMux =
        hitFnSel ? {22'h0, fnSel_q[selIdx]} :
        hitDiv   ? 32'(auxDiv_q) :
        hitLen   ? 32'(pulseLen_q) :
        hitStat  ? 32'(irqStat_q) :
        hitMask  ? 32'(irqMask_q) :
        hitLevel ? {pinOe_q, pinOut_q} : 32'h0;

   // Events: alarm pulse starts, timer done, and a disallowed code written.
   wire logic badSelWr = wrEn && hitFnSel
                         && !gofsAllowed(pwdata[9:0], selIdx < 4'(gofs_pkg::LOW_PIN_COUNT))
                         && (pwdata[9:0] != gofs_pkg::FN_NONE);
   wire logic [EW-1:0] events = {badSelWr, timerDone, alarmPulse & ~alarmPulseDly_q};
   wire logic [EW-1:0] statClr = (wrEn && hitStat) ? pwdata[EW-1:0] : '0;

   // A set in the same cycle as a write-one clear wins.
   assign irqStat_d = (irqStat_q & ~statClr) | events;

   // Pin routing.
   genvar p;
   generate
      for (p = 0; p < NP; p++) begin : gPin
         assign pinOe_d[p]  = gofsAllowed(fnSel_q[p], p < gofs_pkg::LOW_PIN_COUNT);
         assign pinOut_d[p] = pinOe_d[p] & gofsLevel(fnSel_q[p], srcVec);
      end
   endgenerate

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NP; i++) begin
            fnSel_q[i] <= gofs_pkg::FN_NONE;
         end
         auxDiv_q   <= DIV_W'(gofs_pkg::AUX_DIV_RST);
         pulseLen_q <= LEN_W'(gofs_pkg::PULSE_LEN_RST);
         irqMask_q  <= gofs_pkg::IRQ_MASK_RST;
      end else if (wrEn && !wrLevelErr) begin
         if (hitFnSel) fnSel_q[selIdx] <= pwdata[9:0];
         if (hitDiv)   auxDiv_q        <= pwdata[DIV_W-1:0];
         if (hitLen)   pulseLen_q      <= pwdata[LEN_W-1:0];
         if (hitMask)  irqMask_q       <= pwdata[EW-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irqStat_q       <= '0;
         alarmPulseDly_q <= '0;
         irq_q           <= 1'b0;
         pinOut_q        <= '0;
         pinOe_q         <= '0;
      end else begin
         irqStat_q       <= irqStat_d;
         alarmPulseDly_q <= alarmPulse;
         irq_q           <= |(irqStat_q & irqMask_q);
         pinOut_q        <= pinOut_d;
         pinOe_q         <= pinOe_d;
      end
   end

   // The slave answers in the second access cycle; data and error are held with ready.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= apbFirst;
         prdata_q  <= apbFirst && !pwrite ? readMux : '0;
         pslverr_q <= apbFirst && (!mapped || wrLevelErr);
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign pinOut  = pinOut_q;
   assign pinOe   = pinOe_q;
   assign irq     = irq_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   generate
      for (p = 0; p < NP; p++) begin : gChk
         if (p < gofs_pkg::LOW_PIN_COUNT) begin : gLow
            a_aux_clock_route: assert property (
                  fnSel_q[p] == gofs_pkg::FN_AUX_CLOCK |=> pinOe[p] && pinOut[p] == $past(auxClk))
               else $error("aux clock not routed to low pin");
            a_path_detect_route: assert property (
                  fnSel_q[p] == gofs_pkg::FN_PATH_DET
                  |=> pinOe[p] && pinOut[p] == $past(inputPathDetect))
               else $error("input path detect not routed");
            a_ultra_one_route: assert property (
                  fnSel_q[p] == gofs_pkg::FN_ULTRA_ONE
                  |=> pinOe[p] && pinOut[p] == $past(ultrasonicDetectorOne))
               else $error("ultrasonic one flag not routed");
            a_ultra_two_route: assert property (
                  fnSel_q[p] == gofs_pkg::FN_ULTRA_TWO
                  |=> pinOe[p] && pinOut[p] == $past(ultrasonicDetectorTwo))
               else $error("ultrasonic two flag not routed");
            a_event_log_route: assert property (
                  fnSel_q[p] == gofs_pkg::FN_EVLOG_FULL
                  |=> pinOe[p] && pinOut[p] == $past(eventLogNotEmpty))
               else $error("event log status not routed");
         end else begin : gHigh
            a_high_pin_block: assert property (
                  fnSel_q[p] == gofs_pkg::FN_AUX_CLOCK || fnSel_q[p] == gofs_pkg::FN_EVLOG_FULL
                  || fnSel_q[p] == gofs_pkg::FN_PATH_DET |=> !pinOe[p] && !pinOut[p])
               else $error("low-only function driven on high pin");
         end
         a_pwm_one_route: assert property (
               fnSel_q[p] == gofs_pkg::FN_PWM_ONE
               |=> pinOe[p] && pinOut[p] == $past(pulseWidthOutOne))
            else $error("first PWM not routed");
         a_pwm_two_route: assert property (
               fnSel_q[p] == gofs_pkg::FN_PWM_TWO
               |=> pinOe[p] && pinOut[p] == $past(pulseWidthOutTwo))
            else $error("second PWM not routed");
         a_alarm_chan_route: assert property (
               fnSel_q[p] == gofs_pkg::FN_ALARM_BASE + 10'h002
               |=> pinOe[p] && pinOut[p] == $past(alarmPulse[2]))
            else $error("alarm channel three not routed");
         a_timer_two_route: assert property (
               fnSel_q[p] == gofs_pkg::FN_TIMER_TWO
               |=> pinOe[p] && pinOut[p] == $past(timerDone[1]))
            else $error("second timer pulse not routed");
      end
   endgenerate

   a_irq_set_wins: assert property (events[0] |=> irqStat_q[0])
      else $error("alarm event lost from status");

   c_alarm_on_pin: cover property (fnSel_q[0] == gofs_pkg::FN_ALARM_BASE && pinOut[0]);
   c_timer_on_high: cover property (fnSel_q[15] == gofs_pkg::FN_TIMER_ONE && pinOut[15]);
   c_bad_select: cover property (badSelWr);
   c_irq_raised: cover property (irq);

endmodule : gofs_top

// file: gofs_pin_watch.sv
// Board-side pin monitor that counts high cycles and rising edges on one chosen pin.
`timescale 1ns/1ps
module gofs_pin_watch (
   // Clock.
   input  wire logic        clk,
   // Observed pins.
   input  wire logic [15:0] pinOut,
   input  wire logic [15:0] pinOe,
   // Pin choice and synchronous count clear.
   input  wire logic [3:0]  watchPin,
   input  wire logic        clear,
   // Counts since the last clear.
   output int               highCount_q,
   output int               riseCount_q
);
   logic lastLevel_q;
   wire  level = pinOut[watchPin] & pinOe[watchPin];

   initial lastLevel_q = 1'b0;

   always @(posedge clk) begin
      if (clear) begin
         highCount_q <= 0;
         riseCount_q <= 0;
      end else begin
         highCount_q <= highCount_q + int'(level);
         riseCount_q <= riseCount_q + int'(level & ~lastLevel_q);
      end
      lastLevel_q <= level;
   end
endmodule : gofs_pin_watch

// file: gofs_top_bench.sv
// Self-checking bench for the pin output function selector.
`timescale 1ns/1ps
module gofs_top_bench;
   logic        clk;
   logic        nrst;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [5:0]  lvl;
   logic [3:0]  alarmTrig;
   logic [1:0]  timerDone;
   logic [15:0] pinOut;
   logic [15:0] pinOe;
   logic        irq;
   logic [3:0]  watchPin;
   logic        clear;
   int          highCount;
   int          riseCount;
   int          err_count;
   int          n_tests;
   logic [31:0] rdata;
   logic        rerr;

   localparam logic [9:0]  LVL_CODE [6] = '{gofs_pkg::FN_PWM_ONE, gofs_pkg::FN_PWM_TWO,
      gofs_pkg::FN_PATH_DET, gofs_pkg::FN_ULTRA_ONE, gofs_pkg::FN_ULTRA_TWO,
      gofs_pkg::FN_EVLOG_FULL};
   localparam logic [5:0]  LVL_ALL = 6'h03;
   localparam logic [7:0]  RST_ADDR [6] = '{gofs_pkg::OFS_FN_SEL0, gofs_pkg::OFS_AUX_DIV,
      gofs_pkg::OFS_PULSE_LEN, gofs_pkg::OFS_IRQ_STAT, gofs_pkg::OFS_IRQ_MASK,
      gofs_pkg::OFS_PIN_LEVEL};
   localparam logic [31:0] RST_VAL [6] = '{32'h0, 32'h1, 32'h4, 32'h0, 32'h0, 32'h0};

   gofs_top gofs_top_inst (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pulseWidthOutOne(lvl[0]),
      .pulseWidthOutTwo(lvl[1]), .inputPathDetect(lvl[2]), .ultrasonicDetectorOne(lvl[3]),
      .ultrasonicDetectorTwo(lvl[4]), .eventLogNotEmpty(lvl[5]), .alarmTrig(alarmTrig),
      .timerDone(timerDone), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));

   gofs_pin_watch gofs_pin_watch_inst (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
      .watchPin(watchPin), .clear(clear), .highCount_q(highCount), .riseCount_q(riseCount));

   always #20 clk = ~clk;

   function automatic logic [7:0] fn_addr(input int i);
      return gofs_pkg::OFS_FN_SEL0 + 8'(4 * i);
   endfunction : fn_addr

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : check

   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      check($sformatf("write error %h", a), {31'h0, e}, {31'h0, rerr});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b0, a, 32'h0);
      check($sformatf("read data %h", a), d, rdata);
      check($sformatf("read error %h", a), {31'h0, e}, {31'h0, rerr});
   endtask : rd

   // Fires the given triggers once, then counts what the watched pin shows for n cycles.
   task automatic count(input logic [3:0] p, input logic [3:0] al, input logic [1:0] tm,
                        input int n, input int hi, input int rise);
      @(posedge clk);
      watchPin <= p;
      clear <= 1'b1;
      alarmTrig <= al;
      timerDone <= tm;
      @(posedge clk);
      clear <= 1'b0;
      alarmTrig <= 4'h0;
      timerDone <= 2'h0;
      repeat (n) @(posedge clk);
      #1;
      check($sformatf("high cycles pin %0d", p), hi, highCount);
      check($sformatf("rising edges pin %0d", p), rise, riseCount);
   endtask : count

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out

   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      close_out();
   end

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      {paddr, psel, penable, pwrite, pwdata} = '0;
      {lvl, alarmTrig, timerDone, watchPin, clear} = '0;
      err_count = 0;
      n_tests = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      #1;
      check("pins after reset", 32'h0, {pinOe, pinOut});
      for (int i = 0; i < 6; i++) rd(RST_ADDR[i], RST_VAL[i], 1'b0);
      rd(8'h60, 32'h0, 1'b1);
      rd(8'h41, 32'h0, 1'b1);
      wr(gofs_pkg::OFS_PIN_LEVEL, 32'hFFFF_FFFF, 1'b1);
      // Only the selected source may reach the pin; pin 9 refuses the low-only codes.
      for (int k = 0; k < 6; k++) begin
         wr(fn_addr(0), 32'(LVL_CODE[k]), 1'b0);
         wr(fn_addr(8), 32'(LVL_CODE[k]), 1'b0);
         @(posedge clk);
         lvl <= 6'h01 << k;
         repeat (2) @(posedge clk);
         #1;
         check("pins 9 and 1", {28'h0, {2{LVL_ALL[k]}}, 2'h3}, {28'h0, pinOe[8], pinOut[8], pinOe[0], pinOut[0]});
         @(posedge clk);
         lvl <= ~(6'h01 << k);
         repeat (2) @(posedge clk);
         #1;
         check("pins 9 and 1", {28'h0, LVL_ALL[k], 3'h2}, {28'h0, pinOe[8], pinOut[8], pinOe[0], pinOut[0]});
      end
      rd(fn_addr(8), 32'(gofs_pkg::FN_EVLOG_FULL), 1'b0);
      rd(gofs_pkg::OFS_IRQ_STAT, 32'h40, 1'b0);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(gofs_pkg::OFS_IRQ_MASK, 32'h40, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      check("irq unmasked", 32'h1, {31'h0, irq});
      wr(gofs_pkg::OFS_IRQ_STAT, 32'h40, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      check("irq cleared", 32'h0, {31'h0, irq});
      rd(gofs_pkg::OFS_IRQ_STAT, 32'h0, 1'b0);
      // Half period of three cycles gives twelve high cycles in twenty-four.
      wr(gofs_pkg::OFS_AUX_DIV, 32'h3, 1'b0);
      wr(fn_addr(0), 32'(gofs_pkg::FN_AUX_CLOCK), 1'b0);
      wr(fn_addr(8), 32'(gofs_pkg::FN_AUX_CLOCK), 1'b0);
      count(4'h0, 4'h0, 2'h0, 24, 12, 4);
      count(4'h8, 4'h0, 2'h0, 24, 0, 0);
      wr(gofs_pkg::OFS_PULSE_LEN, 32'h5, 1'b0);
      for (int ch = 0; ch < 4; ch++) begin
         wr(fn_addr(15), 32'(gofs_pkg::FN_ALARM_BASE) + 32'(ch), 1'b0);
         count(4'hF, 4'hF ^ (4'h1 << ch), 2'h0, 12, 0, 0);
         count(4'hF, 4'h1 << ch, 2'h0, 12, 5, 1);
      end
      for (int t = 0; t < 2; t++) begin
         wr(fn_addr(1), 32'(gofs_pkg::FN_TIMER_ONE) + 32'(t), 1'b0);
         count(4'h1, 4'h0, 2'h3 ^ (2'h1 << t), 8, 0, 0);
         count(4'h1, 4'h0, 2'h1 << t, 8, 1, 1);
      end
      rd(gofs_pkg::OFS_IRQ_STAT, 32'h7F, 1'b0);
      wr(gofs_pkg::OFS_IRQ_STAT, 32'h3F, 1'b0);
      rd(gofs_pkg::OFS_IRQ_STAT, 32'h40, 1'b0);
      close_out();
   end
endmodule : gofs_top_bench
